// *** rtl/press_stroke_pkg.sv ***
// Constants shared by the press single-stroke controller and its helpers.
package press_stroke_pkg;
    // ---------------------------------------------------------------
    // Clock and time base
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_PERIOD_NS = 1000000;
    localparam int MS_TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 17;
    localparam int MS_PER_S = 1000;
    localparam int MS_W = 10;
    // ---------------------------------------------------------------
    // Acknowledge pulse limits
    // ---------------------------------------------------------------
    localparam int ACK_MIN_SHORT_MS = 100;
    localparam int ACK_MIN_LONG_MS = 350;
    localparam int ACK_MAX_S = 30;
    localparam int ACK_CNT_W = 15;
    localparam logic [ACK_CNT_W-1:0] ACK_MAX_MS = ACK_CNT_W'(ACK_MAX_S * MS_PER_S);
    // ---------------------------------------------------------------
    // Upstroke muting
    // ---------------------------------------------------------------
    localparam int MUTE_S_W = 13;
    localparam int MUTE_MAX_S_LIMIT = 7200;
    // ---------------------------------------------------------------
    // Configuration encodings
    // ---------------------------------------------------------------
    localparam logic [2:0] IL_NONE = 3'h1;
    localparam logic [2:0] IL_ALWAYS = 3'h2;
    localparam logic [2:0] IL_RUN_PERM = 3'h3;
    localparam logic [2:0] IL_SEP_PERM = 3'h4;
    localparam logic [2:0] IL_PERM = 3'h5;
    localparam logic [1:0] MUTE_NONE = 2'h1;
    localparam logic [1:0] MUTE_SAFETY = 2'h2;
    localparam logic [1:0] MUTE_SAFETY_RUN = 2'h3;
    // ---------------------------------------------------------------
    // Synchronised input vector layout and startup fill
    // ---------------------------------------------------------------
    localparam int PIN_N = 7;
    localparam int IDX_RUN = 0;
    localparam int IDX_STATIC = 1;
    localparam int IDX_START = 2;
    localparam int IDX_SAFE = 3;
    localparam int IDX_SEP = 4;
    localparam int IDX_PHASE = 5;
    localparam int IDX_ACK = 6;
    localparam logic [1:0] SYNC_FILL = 2'h3;
endpackage : press_stroke_pkg

// *** rtl/press_ctl_if.sv ***
// Signals shared between the controller and its timing helpers.
`timescale 1ns/10ps
`default_nettype none
interface press_ctl_if;
    import press_stroke_pkg::*;
    logic ms_tick;
    logic ack_lvl;
    logic ack_long;
    logic ack_valid;
    logic phase_lvl;
    logic mute_start;
    logic [MUTE_S_W-1:0] mute_max_s;
    logic mute_window;
    modport ctrl (output ms_tick, ack_lvl, ack_long, phase_lvl, mute_start, mute_max_s,
                  input ack_valid, mute_window);
    modport ack_chk (input ms_tick, ack_lvl, ack_long, output ack_valid);
    modport mute_tmr (input ms_tick, phase_lvl, mute_start, mute_max_s, output mute_window);
endinterface : press_ctl_if
`default_nettype wire

// *** rtl/ack_pulse_check.sv ***
// Validates low-high-low acknowledge pulses by the length of the high phase.
`timescale 1ns/10ps
`default_nettype none
module ack_pulse_check
    import press_stroke_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    press_ctl_if.ack_chk ctl
);
    logic high_ff;
    logic valid_ff;
    logic [ACK_CNT_W-1:0] cnt_ff;
    logic [ACK_CNT_W-1:0] min_ms;

    assign min_ms = ctl.ack_long ? ACK_CNT_W'(ACK_MIN_LONG_MS) : ACK_CNT_W'(ACK_MIN_SHORT_MS);
    assign ctl.ack_valid = valid_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            high_ff <= 1'b0;
        end else begin
            high_ff <= ctl.ack_lvl;
        end
    end

    // The count saturates one past the limit so over-long pulses stay refused.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
        end else if (!ctl.ack_lvl) begin
            cnt_ff <= '0;
        end else if (ctl.ms_tick && cnt_ff <= ACK_MAX_MS) begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= high_ff && !ctl.ack_lvl && cnt_ff >= min_ms && cnt_ff <= ACK_MAX_MS;
        end
    end
endmodule : ack_pulse_check
`default_nettype wire

// *** rtl/upstroke_mute_timer.sv ***
// Time window for upstroke muting, started by the upstroke-phase rising edge.
`timescale 1ns/10ps
`default_nettype none
module upstroke_mute_timer
    import press_stroke_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    press_ctl_if.mute_tmr ctl
);
    logic [MS_W-1:0] ms_ff;
    logic [MUTE_S_W-1:0] sec_ff;
    logic win_ff;

    assign ctl.mute_window = win_ff;

    // Window ends on expiry or phase fall.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ms_ff <= '0;
            sec_ff <= '0;
            win_ff <= 1'b0;
        end else if (ctl.mute_start) begin
            ms_ff <= '0;
            sec_ff <= '0;
            win_ff <= 1'b1;
        end else if (!ctl.phase_lvl) begin
            win_ff <= 1'b0;
        end else if (win_ff && ctl.ms_tick) begin
            if (ms_ff == MS_W'(MS_PER_S - 1)) begin
                ms_ff <= '0;
                sec_ff <= sec_ff + 1'b1;
                if (sec_ff + 1'b1 >= ctl.mute_max_s) begin
                    win_ff <= 1'b0;
                end
            end else begin
                ms_ff <= ms_ff + 1'b1;
            end
        end
    end
endmodule : upstroke_mute_timer
`default_nettype wire

// *** rtl/press_single_stroke_control.sv ***
// Press single-stroke enable controller with restart interlock and upstroke muting.
//
// Functional notes
// - Stroke end rising edge always drops enable.
// - Run request rise with permit raises enable.
// - Unconfigured inputs and outputs have no effect.
// - Pending shows only while all permits high.
// - Deselect: safety low at stroke end does not lock.
// - Mode 1: never interlocked, rise resumes.
// - Mode 2: starts locked, every stop locks.
// - Mode 3: stroke end stop does not lock.
// - Modes 4/5: listed stop causes lock.
// - Jog stops on run fall; single does not.
// - Muting mode 1: no muting at all.
// - Mode 2 mutes safety permit in window.
// - Mode 3 mutes safety and run request.
// - Muting 1 to 7200 s; ack 100/350 ms.
// - Valid ack pulse clears the interlock while pending.
// - Static low or pending forces enable low.
// - Muting ends when its timer expires.
// - Start permit checked only while rising.
`timescale 1ns/10ps
`default_nettype none
module press_single_stroke_control
    import press_stroke_pkg::*;
#(
    parameter int TICK_CYCLES = MS_TICK_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic run_req_i,
    input wire logic static_permit_i,
    input wire logic start_permit_i,
    input wire logic safety_permit_i,
    input wire logic stroke_end_position_i,
    input wire logic upstroke_phase_i,
    input wire logic ack_i,
    input wire logic [2:0] cfg_interlock_mode_i,
    input wire logic cfg_start_permit_en_i,
    input wire logic cfg_safety_permit_en_i,
    input wire logic cfg_run_single_i,
    input wire logic [1:0] cfg_mute_mode_i,
    input wire logic [MUTE_S_W-1:0] cfg_mute_max_s_i,
    input wire logic cfg_ack_long_i,
    input wire logic cfg_sep_deselect_i,
    output logic press_enable_o,
    output logic interlock_pending_o
);
    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << TICK_W)) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end
    if (MUTE_MAX_S_LIMIT >= (1 << MUTE_S_W)) begin : g_bad_mute
        $error("Muting counter too narrow");
    end

    // ---------------------------------------------------------------
    // Input synchronisers and edge detection
    // ---------------------------------------------------------------
    logic [PIN_N-1:0] meta_ff;
    logic [PIN_N-1:0] sync_ff;
    logic [PIN_N-1:0] prev_ff;
    logic [1:0] fill_ff;
    logic edges_ok;
    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] rise;
    logic [PIN_N-1:0] fall;

    assign pins = {ack_i, upstroke_phase_i, stroke_end_position_i, safety_permit_i,
                   start_permit_i, static_permit_i, run_req_i};

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= sync_ff;
        end
    end

    // Edges blocked until history holds real levels.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            fill_ff <= '0;
        end else if (fill_ff != SYNC_FILL) begin
            fill_ff <= fill_ff + 1'b1;
        end
    end

    assign edges_ok = (fill_ff == SYNC_FILL);
    assign rise = edges_ok ? (sync_ff & ~prev_ff) : '0;
    assign fall = edges_ok ? (~sync_ff & prev_ff) : '0;

    // ---------------------------------------------------------------
    // Millisecond time base
    // ---------------------------------------------------------------
    logic [TICK_W-1:0] tick_cnt_ff;
    logic ms_tick_ff;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            tick_cnt_ff <= '0;
            ms_tick_ff <= 1'b0;
        end else if (tick_cnt_ff == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= '0;
            ms_tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 1'b1;
            ms_tick_ff <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Effective permits and muting
    // ---------------------------------------------------------------
    logic run_s;
    logic static_s;
    logic sep_s;
    logic start_ok;
    logic safety_eff;
    logic il_off;
    logic mute_en;
    logic mute_active;
    logic run_muted;
    logic safety_ok;
    logic enable_ff;
    logic interlock_ff;

    press_ctl_if ctl ();

    assign run_s = sync_ff[IDX_RUN];
    assign static_s = sync_ff[IDX_STATIC];
    assign sep_s = sync_ff[IDX_SEP];
    // Absent optional inputs read as satisfied.
    assign start_ok = !cfg_start_permit_en_i || sync_ff[IDX_START];
    assign safety_eff = !cfg_safety_permit_en_i || sync_ff[IDX_SAFE];
    assign il_off = (cfg_interlock_mode_i == IL_NONE);

    // Muting only in modes 2 and 3.
    assign mute_en = (cfg_mute_mode_i == MUTE_SAFETY) || (cfg_mute_mode_i == MUTE_SAFETY_RUN);
    // Bridges the safety permit while the window runs.
    assign mute_active = mute_en && enable_ff && static_s && sync_ff[IDX_PHASE] && ctl.mute_window;
    // Run request is bridged only in mode 3.
    assign run_muted = mute_active && (cfg_mute_mode_i == MUTE_SAFETY_RUN);
    assign safety_ok = safety_eff || mute_active;

    // ---------------------------------------------------------------
    // Helper timers
    // ---------------------------------------------------------------
    assign ctl.ms_tick = ms_tick_ff;
    assign ctl.ack_lvl = sync_ff[IDX_ACK] && !il_off;
    // Ack minimum choice and muting limit.
    assign ctl.ack_long = cfg_ack_long_i;
    assign ctl.mute_max_s = cfg_mute_max_s_i;
    assign ctl.phase_lvl = sync_ff[IDX_PHASE] && mute_en;
    // Timer starts on the phase rising edge.
    assign ctl.mute_start = rise[IDX_PHASE] && mute_en;

    ack_pulse_check u_ack (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ctl(ctl.ack_chk)
    );

    upstroke_mute_timer u_mute (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ctl(ctl.mute_tmr)
    );

    // ---------------------------------------------------------------
    // Stop causes
    // ---------------------------------------------------------------
    logic sep_stop;
    logic run_stop;
    logic static_stop;
    logic safety_stop;
    logic sep_desel;
    logic lock_set;
    logic drop;
    logic start;

    // Stroke end edge stops whatever the configuration.
    assign sep_stop = rise[IDX_SEP];
    // Run fall stops only in jog mode.
    assign run_stop = enable_ff && !cfg_run_single_i && !run_s && !run_muted;
    assign static_stop = fall[IDX_STATIC] || (enable_ff && !static_s);
    assign safety_stop = cfg_safety_permit_en_i && !safety_ok
                         && (enable_ff || fall[IDX_SAFE]);
    // Safety low at the stroke end may skip the lock.
    assign sep_desel = cfg_sep_deselect_i && sep_s;

    // Lock causes differ per mode; the permit causes are shared by modes 2 to 5.
    always_comb begin
        lock_set = 1'b0;
        case (cfg_interlock_mode_i)
            IL_NONE: lock_set = 1'b0;
            IL_ALWAYS: lock_set = (sep_stop && enable_ff) || run_stop;
            // Stroke end stop does not lock.
            IL_RUN_PERM: lock_set = run_stop;
            // Stroke end locks in modes 2 and 4 only.
            IL_SEP_PERM: lock_set = sep_stop && enable_ff;
            IL_PERM: lock_set = 1'b0;
            default: lock_set = 1'b0;
        endcase
        if (!il_off) begin
            lock_set = lock_set || static_stop || (safety_stop && !sep_desel);
        end
    end

    // ---------------------------------------------------------------
    // Restart interlock
    // ---------------------------------------------------------------
    // A set in the same cycle as a valid ack wins, so no stop is lost.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            interlock_ff <= 1'b1;
        end else if (il_off) begin
            interlock_ff <= 1'b0;
        end else if (lock_set) begin
            interlock_ff <= 1'b1;
        end else if (ctl.ack_valid && interlock_pending_o) begin
            interlock_ff <= 1'b0;
        end
    end

    // Pending needs every configured permit high.
    assign interlock_pending_o = interlock_ff && !il_off && static_s && start_ok && safety_eff;

    // ---------------------------------------------------------------
    // Press enable
    // ---------------------------------------------------------------
    assign drop = sep_stop || run_stop || !static_s || (cfg_safety_permit_en_i && !safety_ok)
                  || interlock_ff;
    // Start permit only matters for the rise.
    // Run request rise with permits starts a stroke.
    assign start = !enable_ff && rise[IDX_RUN] && static_s && start_ok && safety_eff
                   && !interlock_ff;

    // Enable comes out of reset low.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            enable_ff <= 1'b0;
        end else if (drop) begin
            enable_ff <= 1'b0;
        end else if (start) begin
            enable_ff <= 1'b1;
        end
    end

    // Static permit gates the output without delay.
    assign press_enable_o = enable_ff && static_s && !interlock_ff;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_sep_drop: assert property (rise[IDX_SEP] |=> !enable_ff)
        else $error("Enable survived a stroke end edge");
    a_start_rise: assert property (start && !sep_stop && !run_stop |=> enable_ff)
        else $error("Enable did not rise on a valid start");
    a_pend_perm: assert property (interlock_pending_o |-> static_s && start_ok && safety_eff)
        else $error("Pending shown without all permits");
    a_mode1_free: assert property (il_off |=> !interlock_ff)
        else $error("Interlock held in mode 1");
    a_mode2_lock: assert property (
        cfg_interlock_mode_i == IL_ALWAYS && enable_ff && rise[IDX_SEP] |=> interlock_ff)
        else $error("Stroke end stop did not lock in mode 2");
    a_ack_clear: assert property (
        $fell(interlock_ff) |-> $past(ctl.ack_valid) || $past(il_off))
        else $error("Interlock cleared without a valid ack");
    a_pend_excl: assert property (interlock_pending_o |-> !enable_ff)
        else $error("Enable high while restart pending");
    a_static_low: assert property (!static_s |-> !press_enable_o)
        else $error("Enable high with static permit low");
    a_start_gate: assert property ($rose(enable_ff) |-> $past(start_ok))
        else $error("Enable rose without start permit");
    a_safety_cut: assert property (
        enable_ff && cfg_safety_permit_en_i && !sync_ff[IDX_SAFE] && !mute_active |=> !enable_ff)
        else $error("Unmuted safety low kept enable");

    c_stroke: cover property (start ##[1:1000] rise[IDX_SEP]);
    c_ack: cover property (interlock_ff ##1 !interlock_ff);
    c_mute: cover property (mute_active && !sync_ff[IDX_SAFE]);
    c_jog_stop: cover property (run_stop && !cfg_run_single_i);
endmodule : press_single_stroke_control
`default_nettype wire

// *** tb/press_contact_model.sv ***
// Behavioural press whose crank drives the stroke-end and upstroke-phase contacts.
`timescale 1ns/10ps
`default_nettype none
module press_contact_model #(
    parameter int STROKE = 150
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic press_enable_i,
    input wire logic hold_i,
    output logic stroke_end_position_o,
    output logic upstroke_phase_o
);
    int pos_ff;
    // The crank turns only while enabled, so a stopped press keeps its angle.
    // The hold input parks the crank inside the upstroke phase.
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pos_ff <= 0;
        end else if (press_enable_i && !(hold_i && pos_ff == 30)) begin
            pos_ff <= (pos_ff == STROKE) ? 0 : pos_ff + 1;
        end
    end
    assign stroke_end_position_o = (pos_ff < 5);
    assign upstroke_phase_o = (pos_ff >= 20) && (pos_ff < 60);
endmodule : press_contact_model
`default_nettype wire

// *** tb/press_single_stroke_control_tb.sv ***
// Self-checking testbench for the press single-stroke controller.
`timescale 1ns/10ps
`default_nettype none
module press_single_stroke_control_tb;
    import press_stroke_pkg::*;
    localparam int TICK = 10;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic run_req = 1'b0, static_permit = 1'b1, start_permit = 1'b1, safety_permit = 1'b1;
    logic ack = 1'b0, hold = 1'b0, single = 1'b0, st_en = 1'b0, sa_en = 1'b0;
    logic ack_long = 1'b0, sep = 1'b0;
    logic [2:0] il = 3'h1;
    logic [1:0] mute = 2'h1;
    logic [MUTE_S_W-1:0] mute_s = 13'h0001;
    logic stroke_end, phase, press_enable, pending;
    int n_mismatch = 0;
    int checks_done = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    press_single_stroke_control #(.TICK_CYCLES(TICK)) i_press_single_stroke_control (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_req_i(run_req),
        .static_permit_i(static_permit), .start_permit_i(start_permit),
        .safety_permit_i(safety_permit), .stroke_end_position_i(stroke_end),
        .upstroke_phase_i(phase), .ack_i(ack), .cfg_interlock_mode_i(il),
        .cfg_start_permit_en_i(st_en), .cfg_safety_permit_en_i(sa_en),
        .cfg_run_single_i(single), .cfg_mute_mode_i(mute), .cfg_mute_max_s_i(mute_s),
        .cfg_ack_long_i(ack_long), .cfg_sep_deselect_i(sep),
        .press_enable_o(press_enable), .interlock_pending_o(pending));

    press_contact_model i_press_contact_model (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .press_enable_i(press_enable), .hold_i(hold),
        .stroke_end_position_o(stroke_end), .upstroke_phase_o(phase));

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s is %b", $time, what, got);
        end
    endtask : chk

    task automatic restart(input logic [2:0] m, input logic sg, input logic [1:0] mu,
                           input logic se, input logic sa, input logic lg, input logic ds);
        rst_i = 1'b1;
        {il, single, mute, st_en, sa_en, ack_long, sep} = {m, sg, mu, se, sa, lg, ds};
        {run_req, static_permit, start_permit, safety_permit, ack, hold} = 6'h1C;
        cyc(12);
        rst_i = 1'b0;
        cyc(5);
    endtask : restart

    task automatic ack_pulse(input int ms);
        ack = 1'b1;
        cyc(ms * TICK);
        ack = 1'b0;
        cyc(20);
    endtask : ack_pulse

    task automatic results;
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_basic;
        restart(3'h1, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk("enable after reset", press_enable, 1'b0);
        run_req = 1'b1;
        cyc(6);
        chk("enable on run", press_enable, 1'b1);
        cyc(170);
        chk("enable at stroke end", press_enable, 1'b0);
        chk("pending mode 1", pending, 1'b0);
        run_req = 1'b0;
        cyc(4);
        run_req = 1'b1;
        cyc(6);
        chk("enable on rerun", press_enable, 1'b1);
        run_req = 1'b0;
        cyc(6);
        chk("enable jog stop", press_enable, 1'b0);
        run_req = 1'b1;
        cyc(6);
        chk("enable jog resume", press_enable, 1'b1);
        start_permit = 1'b0;
        safety_permit = 1'b0;
        cyc(4);
        chk("enable absent permits", press_enable, 1'b1);
        static_permit = 1'b0;
        cyc(3);
        chk("enable static low", press_enable, 1'b0);
        $display("test basic finished");
    endtask : t_basic

    task automatic t_interlock;
        restart(3'h2, 1'b0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("pending after reset", pending, 1'b1);
        run_req = 1'b1;
        cyc(6);
        chk("enable while locked", press_enable, 1'b0);
        run_req = 1'b0;
        ack_pulse(60);
        chk("pending short ack", pending, 1'b1);
        ack_pulse(105);
        chk("pending valid ack", pending, 1'b0);
        run_req = 1'b1;
        cyc(6);
        chk("enable unlocked", press_enable, 1'b1);
        run_req = 1'b0;
        cyc(6);
        chk("pending run stop", pending, 1'b1);
        safety_permit = 1'b0;
        cyc(4);
        chk("pending permit low", pending, 1'b0);
        safety_permit = 1'b1;
        cyc(4);
        chk("pending permit back", pending, 1'b1);
        $display("test interlock finished");
    endtask : t_interlock

    task automatic t_long_ack;
        restart(3'h3, 1'b0, 2'h1, 1'b0, 1'b1, 1'b1, 1'b0);
        ack_pulse(200);
        chk("pending 200 ms ack", pending, 1'b1);
        ack_pulse(360);
        chk("pending 360 ms ack", pending, 1'b0);
        run_req = 1'b1;
        cyc(175);
        chk("enable at stroke end", press_enable, 1'b0);
        chk("pending stroke end", pending, 1'b0);
        run_req = 1'b0;
        cyc(4);
        run_req = 1'b1;
        cyc(6);
        chk("enable new stroke", press_enable, 1'b1);
        static_permit = 1'b0;
        cyc(4);
        static_permit = 1'b1;
        cyc(4);
        chk("pending static fall", pending, 1'b1);
        $display("test long_ack finished");
    endtask : t_long_ack

    task automatic t_single;
        restart(3'h1, 1'b1, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
        start_permit = 1'b0;
        run_req = 1'b1;
        cyc(6);
        chk("enable start low", press_enable, 1'b0);
        start_permit = 1'b1;
        run_req = 1'b0;
        cyc(4);
        run_req = 1'b1;
        cyc(6);
        start_permit = 1'b0;
        run_req = 1'b0;
        cyc(6);
        chk("enable single start", press_enable, 1'b1);
        $display("test single finished");
    endtask : t_single

    task automatic t_muting;
        restart(3'h2, 1'b0, 2'h3, 1'b0, 1'b1, 1'b0, 1'b0);
        ack_pulse(105);
        hold = 1'b1;
        run_req = 1'b1;
        cyc(40);
        safety_permit = 1'b0;
        run_req = 1'b0;
        cyc(20);
        chk("enable while muted", press_enable, 1'b1);
        cyc(10100);
        chk("enable after expiry", press_enable, 1'b0);
        safety_permit = 1'b1;
        cyc(4);
        chk("pending after expiry", pending, 1'b1);
        $display("test muting finished");
    endtask : t_muting

    task automatic t_deselect;
        restart(3'h5, 1'b0, 2'h1, 1'b0, 1'b1, 1'b0, 1'b1);
        ack_pulse(105);
        run_req = 1'b1;
        cyc(175);
        chk("pending stroke end", pending, 1'b0);
        safety_permit = 1'b0;
        cyc(4);
        safety_permit = 1'b1;
        cyc(4);
        chk("pending deselect", pending, 1'b0);
        $display("test deselect finished");
    endtask : t_deselect

    // Mode 4 locks on the stroke end but not on a run stop; muting mode 2 bridges safety only.
    task automatic t_mode4;
        restart(3'h4, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
        chk("pending mode 4 reset", pending, 1'b1);
        ack_pulse(105);
        hold = 1'b1;
        run_req = 1'b1;
        cyc(40);
        safety_permit = 1'b0;
        cyc(20);
        chk("enable safety muted", press_enable, 1'b1);
        safety_permit = 1'b1;
        cyc(4);
        run_req = 1'b0;
        cyc(6);
        chk("enable run not muted", press_enable, 1'b0);
        chk("pending mode 4 run stop", pending, 1'b0);
        hold = 1'b0;
        run_req = 1'b1;
        cyc(135);
        chk("enable mode 4 stroke end", press_enable, 1'b0);
        chk("pending mode 4 stroke end", pending, 1'b1);
        $display("test mode4 finished");
    endtask : t_mode4

    // ---------------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------------
    initial begin
        t_basic();
        t_interlock();
        t_long_ack();
        t_single();
        t_muting();
        t_deselect();
        t_mode4();
        results();
    end

    // The tests need about 21700 cycles; the margin covers slow answers only.
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        n_mismatch++;
        results();
    end
endmodule : press_single_stroke_control_tb
`default_nettype wire
